// [core/read_port_defines.svh]
`ifndef READ_PORT_DEFINES_SVH
`define READ_PORT_DEFINES_SVH

// ************************************************************
// Result word and frame constants
// ************************************************************
`define RP_RESULT_BITS 5'h16
`define RP_SENT_RESET 5'h00
`define RP_CTRL_RESET 8'h00
`define RP_IN_MODE_RESET 2'h0
`define RP_CHAIN_CODE0 8'h00
`define RP_CHAIN_CODE1 8'h01

// ************************************************************
// Output control field codes
// ************************************************************
`define RP_LAUNCH_EDL 2'h1
`define RP_LAUNCH_SRC 2'h3
`define RP_WIDTH_DUAL 2'h2
`define RP_WIDTH_QUAD 2'h3
`define RP_CLK_EXT 2'h0
`define RP_CLK_INT 2'h1
`define RP_CLK_DIV2 2'h2
`define RP_CLK_DIV4 2'h3

// ************************************************************
// Divider limits and lane group sizes
// ************************************************************
`define RP_DIV_LIMIT_INT 2'h0
`define RP_DIV_LIMIT_DIV2 2'h1
`define RP_DIV_LIMIT_DIV4 2'h3
`define RP_GROUP_ONE 3'h1
`define RP_GROUP_TWO 3'h2
`define RP_GROUP_FOUR 3'h4

`endif

// [core/read_port_pkg.sv]
`default_nettype none
`include "read_port_defines.svh"

package read_port_pkg;

  // ************************************************************
  // Output control register layout
  // ************************************************************
  typedef struct packed {
    logic [1:0] sync_clock_source_sel; // Sync clock source
    logic spare; // Unused bit
    logic ddr; // Double-rate select
    logic [1:0] lane_width_sel; // Lane count
    logic [1:0] output_launch_mode; // Legacy, early or sync
  } cfg_s;

  // Frame kind
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_LEGACY = 2'b01,
    FR_SYNC = 2'b10
  } frame_e;

  // ************************************************************
  // Module state records
  // ************************************************************
  typedef struct packed {
    logic [21:0] sr; // Bits still to send
    logic [3:0] lanes; // Driven lane values
    logic [4:0] sent; // Bits presented so far
  } shift_state_s;

  typedef struct packed {
    logic [1:0] cnt; // Divider count
    logic tick; // Toggle request
  } div_state_s;

  typedef struct packed {
    logic cs_q; // Previous chip select
    logic sclk_q; // Previous serial clock
    cfg_s cfg; // Latched output control
    logic [1:0] in_mode; // Latched input phase mode
    logic rck; // Ready/clock pin value
    frame_e frame; // Current frame kind
  } main_state_s;

  // Bits per launch for a width code
  function automatic logic [2:0] group_bits(input logic [1:0] width);
    case (width)
      `RP_WIDTH_QUAD: group_bits = `RP_GROUP_FOUR;
      `RP_WIDTH_DUAL: group_bits = `RP_GROUP_TWO;
      default: group_bits = `RP_GROUP_ONE;
    endcase
  endfunction

endpackage
`default_nettype wire

// [core/clock_source_divider.sv]
`timescale 1ns/1ps
`default_nettype none
`include "read_port_defines.svh"

module clock_source_divider (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  input wire logic [1:0] sel_in,
  output logic tick_out
);

  // ************************************************************
  // State
  // ************************************************************
  read_port_pkg::div_state_s st_r; // Registered state
  read_port_pkg::div_state_s st_nxt; // Next state
  logic [1:0] limit; // Terminal count for source

  // Next-state logic: one tick per divided period
  always_comb begin
    st_nxt = st_r;
    case (sel_in)
      `RP_CLK_DIV2: limit = `RP_DIV_LIMIT_DIV2; // Half rate
      `RP_CLK_DIV4: limit = `RP_DIV_LIMIT_DIV4; // Quarter rate
      default: limit = `RP_DIV_LIMIT_INT; // Oscillator rate
    endcase
    if (!run_in) begin
      // Idle between frames
      st_nxt.cnt = 2'h0;
      st_nxt.tick = 1'b0;
    end else if (st_r.cnt >= limit) begin
      // Period done
      st_nxt.cnt = 2'h0;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 2'h1;
      st_nxt.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;

endmodule // clock_source_divider
`default_nettype wire

// [core/lane_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "read_port_defines.svh"

module lane_shifter (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic load_in,
  input wire logic present_in,
  input wire logic shift_in,
  input wire logic clear_in,
  input wire logic [1:0] width_in,
  input wire logic [21:0] data_in,
  input wire logic fill_in,
  output logic [3:0] lanes_out,
  output logic done_out
);

  // ************************************************************
  // State
  // ************************************************************
  read_port_pkg::shift_state_s st_r; // Registered state
  read_port_pkg::shift_state_s st_nxt; // Next state
  logic [4:0] bits; // Bits per launch

  // Top group of a word, lane 0 takes the oldest bit
  function automatic logic [3:0] group(input logic [21:0] w, input logic [1:0] width);
    case (width)
      `RP_WIDTH_QUAD: group = {w[18], w[19], w[20], w[21]};
      `RP_WIDTH_DUAL: group = {2'h0, w[20], w[21]};
      default: group = {3'h0, w[21]};
    endcase
  endfunction

  // Word after one launch; single lane takes the fill bit
  function automatic logic [21:0] advance(input logic [21:0] w, input logic [1:0] width,
                                          input logic fill);
    case (width)
      `RP_WIDTH_QUAD: advance = {w[17:0], 4'h0};
      `RP_WIDTH_DUAL: advance = {w[19:0], 2'h0};
      default: advance = {w[20:0], fill};
    endcase
  endfunction

  // Next-state logic: load, launch or clear
  always_comb begin
    st_nxt = st_r;
    bits = {2'h0, read_port_pkg::group_bits(width_in)};
    if (clear_in) begin
      // Lanes rest low between frames
      st_nxt.lanes = 4'h0;
    end else if (load_in) begin
      // MSB first, optionally shown at once
      st_nxt.sr = present_in ? advance(data_in, width_in, fill_in) : data_in;
      st_nxt.lanes = present_in ? group(data_in, width_in) : 4'h0;
      st_nxt.sent = present_in ? bits : `RP_SENT_RESET;
    end else if (shift_in) begin
      // All active lanes launch together
      st_nxt.lanes = group(st_r.sr, width_in);
      st_nxt.sr = advance(st_r.sr, width_in, fill_in);
      if (st_r.sent < `RP_RESULT_BITS) begin
        st_nxt.sent = st_r.sent + bits;
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lanes_out = st_r.lanes;
  assign done_out = (st_r.sent >= `RP_RESULT_BITS);

endmodule // lane_shifter
`default_nettype wire

// [core/adc_multilane_read_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "read_port_defines.svh"

// What this block does
// - Lane count raised to two or four
// - Launch edge follows polarity and phase
// - Dual width drives lanes zero and one
// - Quad width drives all four lanes
// - Control codes pick width; fewer clocks needed
// - Early launch only for phase modes 00/10
// - Early launch moves bits half clock earlier
// - Ready/clock pin low in legacy frames
// - No chain pass-through unless control 00h/01h
// - Zeros follow the result on lanes outside chain mode
// - Sync mode drives clock aligned with data
// - Sync clock from serial or divided oscillator
// - All widths also work in sync mode
// - Sync dual launches two bits on rise
// - Sync quad launches four bits on rise
// - Reset returns to idle-low, rising-capture mode
// - Double rate launches on both sync clock edges; legacy frames ignore it

module adc_multilane_read_port (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic sclk_in,
  input wire logic cfg_write_in,
  input wire logic [7:0] output_control_reg_in,
  input wire logic [7:0] input_control_reg_in,
  input wire logic [21:0] result_in,
  input wire logic daisy_in,
  output logic out_lane0_out,
  output logic out_lane1_out,
  output logic out_lane2_out,
  output logic out_lane3_out,
  output logic ready_clock_out
);

  // ************************************************************
  // State and decode
  // ************************************************************
  read_port_pkg::main_state_s st_r; // Registered state
  read_port_pkg::main_state_s st_nxt; // Next state
  logic frame; // Chip select active
  logic cs_fall; // Frame start
  logic sclk_rise; // Serial clock rose
  logic sclk_fall; // Serial clock fell
  logic early_launch; // Early launch in force
  logic edge_rise; // Legacy launch on rising edge
  logic legacy_shift; // Legacy launch event
  logic rck_rise; // Output clock rises
  logic rck_fall; // Output clock falls
  logic sync_shift; // Sync launch event
  logic shift; // Any launch event
  logic present; // MSB shown at frame start
  logic chain_mode; // Pass-through allowed
  logic fill; // Bit fed behind the result
  logic div_run; // Divider enable
  logic tick; // Divided oscillator tick
  logic done; // Whole result presented
  logic [3:0] lanes; // Shifter lane values

  // ************************************************************
  // Frame control
  // ************************************************************

  // Next-state and event logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_q = cs_b_in;
    st_nxt.sclk_q = sclk_in;
    frame = !cs_b_in;
    cs_fall = st_r.cs_q && !cs_b_in;
    sclk_rise = !st_r.sclk_q && sclk_in;
    sclk_fall = st_r.sclk_q && !sclk_in;
    // Early launch ignored for phase modes 01/11
    early_launch = (st_r.cfg.output_launch_mode == `RP_LAUNCH_EDL) && !st_r.in_mode[0];
    // Modes 01/10 launch on rise, 00/11 on fall; early launch moves 00 to rise and 10 to fall
    edge_rise = (st_r.in_mode[1] ^ st_r.in_mode[0]) ^ early_launch;
    legacy_shift = (st_r.frame == read_port_pkg::FR_LEGACY) && frame
                   && (edge_rise ? sclk_rise : sclk_fall);
    chain_mode = (8'(st_r.cfg) == `RP_CHAIN_CODE0) || (8'(st_r.cfg) == `RP_CHAIN_CODE1);
    fill = chain_mode ? daisy_in : 1'b0;
    // First bit at chip select for phase-low modes, except with sync launch
    present = (st_r.cfg.output_launch_mode != `RP_LAUNCH_SRC) && !st_r.in_mode[0];
    div_run = frame && (st_r.frame == read_port_pkg::FR_SYNC)
              && (st_r.cfg.sync_clock_source_sel != `RP_CLK_EXT);

    // Frame kind
    case (st_r.frame)
      read_port_pkg::FR_IDLE: begin
        // Kind fixed at chip select
        if (cs_fall) begin
          if (st_r.cfg.output_launch_mode == `RP_LAUNCH_SRC) begin
            st_nxt.frame = read_port_pkg::FR_SYNC;
          end else begin
            st_nxt.frame = read_port_pkg::FR_LEGACY;
          end
        end
      end
      read_port_pkg::FR_LEGACY, read_port_pkg::FR_SYNC: begin
        if (!frame) begin
          st_nxt.frame = read_port_pkg::FR_IDLE;
        end
      end
      default: begin
        st_nxt.frame = read_port_pkg::FR_IDLE;
      end
    endcase

    // Output clock: low outside sync frames
    if (!frame || st_r.frame != read_port_pkg::FR_SYNC) begin
      st_nxt.rck = 1'b0;
    end else if (st_r.cfg.sync_clock_source_sel == `RP_CLK_EXT) begin
      // Follows the host serial clock
      st_nxt.rck = sclk_in;
    end else if (tick && (!done || st_r.rck)) begin
      // Divided oscillator; stops low after last group
      st_nxt.rck = !st_r.rck;
    end
    rck_rise = !st_r.rck && st_nxt.rck;
    rck_fall = st_r.rck && !st_nxt.rck;
    // Launch with the clock edge, both edges in double rate
    sync_shift = (st_r.frame == read_port_pkg::FR_SYNC) && frame
                 && (rck_rise || (st_r.cfg.ddr && rck_fall));
    shift = legacy_shift || sync_shift;

    // Configuration only between frames
    if (cfg_write_in && cs_b_in) begin
      st_nxt.cfg = read_port_pkg::cfg_s'(output_control_reg_in);
      st_nxt.in_mode = input_control_reg_in[1:0];
    end
  end

  // State register; reset restores idle-low, rising capture
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r.cs_q <= 1'b1;
      st_r.sclk_q <= 1'b0;
      st_r.cfg <= read_port_pkg::cfg_s'(`RP_CTRL_RESET);
      st_r.in_mode <= `RP_IN_MODE_RESET;
      st_r.rck <= 1'b0;
      st_r.frame <= read_port_pkg::FR_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Sub-blocks
  // ************************************************************

  // Divided internal oscillator
  clock_source_divider u_divider (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(div_run),
    .sel_in(st_r.cfg.sync_clock_source_sel),
    .tick_out(tick)
  );

  // Result serializer
  lane_shifter u_shifter (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .load_in(cs_fall),
    .present_in(present),
    .shift_in(shift && !cs_fall),
    .clear_in(!frame),
    .width_in(st_r.cfg.lane_width_sel),
    .data_in(result_in),
    .fill_in(fill),
    .lanes_out(lanes),
    .done_out(done)
  );

  // Pins come straight from registers
  assign out_lane0_out = lanes[0];
  assign out_lane1_out = lanes[1];
  assign out_lane2_out = lanes[2];
  assign out_lane3_out = lanes[3];
  assign ready_clock_out = st_r.rck;

  // ************************************************************
  // Checks
  // ************************************************************

  property p_rdy_low_legacy;
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_r.frame == read_port_pkg::FR_LEGACY) |-> !ready_clock_out;
  endproperty
  a_rdy_low_legacy: assert property (p_rdy_low_legacy) else $error("ready pin high in legacy frame");

  property p_dual_upper_idle;
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_r.cfg.lane_width_sel == `RP_WIDTH_DUAL) |-> (!out_lane2_out && !out_lane3_out);
  endproperty
  a_dual_upper_idle: assert property (p_dual_upper_idle) else $error("upper lanes active in dual");

  property p_single_lane_only;
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_r.cfg.lane_width_sel[1] == 1'b0) |-> (lanes[3:1] == 3'h0);
  endproperty
  a_single_lane_only: assert property (p_single_lane_only) else $error("extra lanes in single");

  property p_mode00_hold_on_rise;
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_r.frame == read_port_pkg::FR_LEGACY && st_r.in_mode == 2'h0 && !early_launch && sclk_rise && frame)
    |=> $stable(lanes);
  endproperty
  a_mode00_hold_on_rise: assert property (p_mode00_hold_on_rise) else $error("launch on capture edge");

  property p_edl_ignored_mode01;
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_r.frame == read_port_pkg::FR_LEGACY && st_r.in_mode == 2'h1 && sclk_fall && !cs_fall && frame)
    |=> $stable(lanes);
  endproperty
  a_edl_ignored_mode01: assert property (p_edl_ignored_mode01) else $error("early launch in mode 01");

  property p_edl_hold_on_fall;
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_r.frame == read_port_pkg::FR_LEGACY && early_launch && st_r.in_mode == 2'h0 && sclk_fall && frame)
    |=> $stable(lanes);
  endproperty
  a_edl_hold_on_fall: assert property (p_edl_hold_on_fall) else $error("early launch on wrong edge");

  property p_zeros_after_result;
    @(posedge clk_in) disable iff (!rst_b_in)
    (done && !chain_mode && shift && !cs_fall && frame) |=> (lanes == 4'h0);
  endproperty
  a_zeros_after_result: assert property (p_zeros_after_result) else $error("nonzero after result");

  property p_sdr_launch_on_rise;
    @(posedge clk_in) disable iff (!rst_b_in)
    ($changed(lanes) && !cs_b_in && $past(!cs_b_in) && $past(st_r.frame == read_port_pkg::FR_SYNC)
     && !st_r.cfg.ddr) |-> $rose(ready_clock_out);
  endproperty
  a_sdr_launch_on_rise: assert property (p_sdr_launch_on_rise) else $error("sync data off rising edge");

  property p_int_clock_on_tick;
    @(posedge clk_in) disable iff (!rst_b_in)
    ($changed(ready_clock_out) && !cs_b_in && $past(st_r.frame == read_port_pkg::FR_SYNC)
     && st_r.cfg.sync_clock_source_sel != `RP_CLK_EXT) |-> $past(tick);
  endproperty
  a_int_clock_on_tick: assert property (p_int_clock_on_tick) else $error("sync clock toggled without tick");

  property p_reset_mode;
    @(posedge clk_in)
    $rose(rst_b_in) |-> (st_r.in_mode == `RP_IN_MODE_RESET);
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("phase mode not reset");

  property p_first_bit_at_select;
    @(posedge clk_in) disable iff (!rst_b_in)
    (cs_fall && present)
    |=> (lanes[0] == $past(result_in[21]));
  endproperty
  a_first_bit_at_select: assert property (p_first_bit_at_select) else $error("msb not shown at select");

  property p_late_first_bit;
    @(posedge clk_in) disable iff (!rst_b_in)
    (cs_fall && st_r.in_mode[0])
    |=> (lanes == 4'h0);
  endproperty
  a_late_first_bit: assert property (p_late_first_bit) else $error("bit shown before launch edge");

  property p_dual_lane_order;
    @(posedge clk_in) disable iff (!rst_b_in)
    (cs_fall && present && st_r.cfg.lane_width_sel == `RP_WIDTH_DUAL)
    |=> (lanes == {2'h0, $past(result_in[20]), $past(result_in[21])});
  endproperty
  a_dual_lane_order: assert property (p_dual_lane_order) else $error("dual lane order wrong");

  property p_quad_lane_order;
    @(posedge clk_in) disable iff (!rst_b_in)
    (cs_fall && present && st_r.cfg.lane_width_sel == `RP_WIDTH_QUAD)
    |=> (lanes == {$past(result_in[18]), $past(result_in[19]), $past(result_in[20]), $past(result_in[21])});
  endproperty
  a_quad_lane_order: assert property (p_quad_lane_order) else $error("quad lane order wrong");

  property p_idle_clock_low;
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_r.frame == read_port_pkg::FR_IDLE)
    |-> !ready_clock_out;
  endproperty
  a_idle_clock_low: assert property (p_idle_clock_low) else $error("ready pin high between frames");

  property p_ext_clock_follows;
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_r.frame == read_port_pkg::FR_SYNC && frame && st_r.cfg.sync_clock_source_sel == `RP_CLK_EXT)
    |=> (ready_clock_out == $past(sclk_in));
  endproperty
  a_ext_clock_follows: assert property (p_ext_clock_follows) else $error("sync clock off serial clock");

  property p_osc_clock_parks;
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_r.frame == read_port_pkg::FR_SYNC && frame && st_r.cfg.sync_clock_source_sel != `RP_CLK_EXT
     && done && !ready_clock_out) |=> !ready_clock_out;
  endproperty
  a_osc_clock_parks: assert property (p_osc_clock_parks) else $error("sync clock ran after result");

endmodule // adc_multilane_read_port
`default_nettype wire

// [sim/host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Host controller model: frames, serial clock, lane capture
// ************************************************************
module host_model (
  input wire logic clk_in,
  input wire logic [3:0] lanes_in,
  input wire logic rck_in,
  input wire logic ddr_in,
  output logic cs_b_out,
  output logic sclk_out
);
  localparam int HALF = 4; // Clocks per serial half period
  logic [3:0] cap_q[$]; // Capture edge samples
  logic [3:0] opp_q[$]; // Opposite edge samples
  logic [3:0] syn_q[$]; // Device clock samples
  logic rck_q = 1'b0; // Last device clock level
  logic in_leg = 1'b0; // Legacy frame open
  logic in_syn = 1'b0; // Sync frame open
  int rck_high = 0; // Device clock seen high in legacy frames
  int rise_at = -1; // Cycle of last rise
  int rise_gap = -1; // Gap between first two rises
  int cyc = 0; // Free cycle count

  // Idle: deselected, clock still
  initial begin
    cs_b_out = 1'b1;
    sclk_out = 1'b0;
  end

  // Capture lanes on device clock rises, and on falls in double rate
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (in_leg && rck_in !== 1'b0) begin
      rck_high <= rck_high + 1;
    end
    if (in_syn && rck_in === 1'b1 && rck_q === 1'b0) begin
      syn_q.push_back(lanes_in);
      if (rise_at >= 0 && rise_gap < 0) begin
        rise_gap <= cyc - rise_at;
      end
      rise_at <= cyc;
    end else if (in_syn && ddr_in && rck_in === 1'b0 && rck_q === 1'b1) begin
      syn_q.push_back(lanes_in);
    end
    rck_q <= rck_in;
  end

  // Legacy frame: sample just before each serial clock edge
  task automatic legacy(input logic [1:0] mode, input int nclk);
    cap_q.delete();
    opp_q.delete();
    @(posedge clk_in);
    #2;
    // Clock parked at its polarity as the frame opens
    sclk_out = mode[1];
    cs_b_out = 1'b0;
    in_leg = 1'b1;
    for (int i = 0; i < nclk; i++) begin
      repeat (HALF) @(posedge clk_in);
      #2;
      if (mode[0]) opp_q.push_back(lanes_in);
      else cap_q.push_back(lanes_in);
      sclk_out = ~sclk_out;
      repeat (HALF) @(posedge clk_in);
      #2;
      if (mode[0]) cap_q.push_back(lanes_in);
      else opp_q.push_back(lanes_in);
      sclk_out = ~sclk_out;
    end
    repeat (HALF) @(posedge clk_in);
    #2;
    cs_b_out = 1'b1;
    in_leg = 1'b0;
    repeat (2) @(posedge clk_in);
  endtask

  // Sync frame: toggle serial clock only when it is the source
  task automatic sync(input logic serial, input int nhalf);
    syn_q.delete();
    rise_at = -1;
    rise_gap = -1;
    @(posedge clk_in);
    #2;
    // Idle low, even after a high-polarity legacy frame
    sclk_out = 1'b0;
    cs_b_out = 1'b0;
    in_syn = 1'b1;
    for (int i = 0; i < nhalf; i++) begin
      repeat (HALF) @(posedge clk_in);
      #2;
      if (serial) sclk_out = ~sclk_out;
    end
    repeat (HALF) @(posedge clk_in);
    #2;
    cs_b_out = 1'b1;
    in_syn = 1'b0;
    sclk_out = 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
endmodule // host_model

`default_nettype wire

// [sim/adc_multilane_read_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module adc_multilane_read_port_tb_top;
  logic clk_in = 1'b0; // System clock
  logic rst_b_in = 1'b0; // Async reset
  logic cfg_write_in = 1'b0; // Config strobe
  logic [7:0] ctrl = 8'h00; // Output control value
  logic [7:0] phase = 8'h00; // Input control value
  logic [21:0] result = 22'h000000; // Result word
  logic daisy = 1'b1; // Chain input, held high
  logic cs_b; // Chip select from host
  logic sclk; // Serial clock from host
  logic [3:0] lanes; // Data lanes
  logic rck; // Ready/clock pin
  int errors = 0; // Mismatch count
  int checked = 0; // Comparison count

  // 10 MHz clock
  initial begin
    forever #50 clk_in = ~clk_in;
  end

  adc_multilane_read_port DUT (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .cs_b_in(cs_b),
    .sclk_in(sclk),
    .cfg_write_in(cfg_write_in),
    .output_control_reg_in(ctrl),
    .input_control_reg_in(phase),
    .result_in(result),
    .daisy_in(daisy),
    .out_lane0_out(lanes[0]),
    .out_lane1_out(lanes[1]),
    .out_lane2_out(lanes[2]),
    .out_lane3_out(lanes[3]),
    .ready_clock_out(rck)
  );

  host_model host (
    .clk_in(clk_in),
    .lanes_in(lanes),
    .rck_in(rck),
    .ddr_in(ctrl[4]),
    .cs_b_out(cs_b),
    .sclk_out(sclk)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input string what, input logic [21:0] seen, input logic [21:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Group k of the word, MSB first, lane0 oldest
  function automatic logic [3:0] grp(input logic [21:0] w, input int g, input int k, input logic fill);
    logic [3:0] v;
    int n;
    v = 4'h0;
    for (int i = 0; i < g; i++) begin
      n = 21 - k * g - i;
      v[i] = (n > 21) ? 1'b0 : ((n >= 0) ? w[n] : fill);
    end
    return v;
  endfunction

  task automatic reset_dut();
    @(posedge clk_in);
    #2;
    rst_b_in = 1'b0;
    repeat (5) @(posedge clk_in);
    #2;
    check("reset_pins", {rck, lanes}, 22'h000000);
    rst_b_in = 1'b1;
    repeat (2) @(posedge clk_in);
  endtask

  task automatic configure(input logic [7:0] oc, input logic [7:0] ic);
    @(posedge clk_in);
    #2;
    ctrl = oc;
    phase = ic;
    cfg_write_in = 1'b1;
    @(posedge clk_in);
    #2;
    cfg_write_in = 1'b0;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic legacy_run(input logic [1:0] md, input logic [1:0] lm, input logic [1:0] w, input int extra,
                            input logic wr);
    logic [7:0] oc;
    logic [3:0] m;
    logic fill;
    int g;
    int n;
    int sh;
    oc = wr ? {2'($urandom), 2'h0, w, lm} : 8'h00;
    if (wr) configure(oc, {6'h00, md});
    g = (w == 2'h3) ? 4 : ((w == 2'h2) ? 2 : 1);
    m = 4'((1 << g) - 1);
    n = (21 + g) / g + extra;
    sh = md[0] ? -1 : ((lm == 2'h1) ? 1 : 0);
    fill = ((oc == 8'h00 || oc == 8'h01) && g == 1) ? daisy : 1'b0;
    result = 22'($urandom);
    host.legacy(md, n);
    for (int k = 0; k < n; k++) begin
      check("lane_capture", 22'(host.cap_q[k] & m), 22'(grp(result, g, k, fill) & m));
      check("lane_opposite", 22'(host.opp_q[k] & m), 22'(grp(result, g, k + sh, fill) & m));
    end
    check("ready_low", 22'(host.rck_high), 22'h000000);
  endtask

  task automatic sync_run(input logic [1:0] src, input logic [1:0] w, input logic ddr);
    logic [7:0] oc;
    logic [3:0] m;
    int g;
    int n;
    int cnt;
    oc = {src, 1'b0, ddr, w, 2'h3};
    configure(oc, {6'h00, 2'($urandom)});
    g = (w == 2'h3) ? 4 : ((w == 2'h2) ? 2 : 1);
    m = 4'((1 << g) - 1);
    n = (21 + g) / g;
    // Oscillator clock parks low; in double rate that fall launches one zero group
    cnt = n + ((src != 2'h0 && ddr && n % 2 == 1) ? 1 : 0);
    result = 22'($urandom);
    host.sync(src == 2'h0, (src == 2'h0) ? (ddr ? n : 2 * n) : 100);
    check("sync_count", 22'(host.syn_q.size()), 22'(cnt));
    check("sync_gap", 22'(host.rise_gap), 22'((src == 2'h0) ? 8 : (1 << src)));
    for (int k = 0; k < cnt; k++) begin
      check("sync_lanes", 22'(host.syn_q[k] & m), 22'(grp(result, g, k, 1'b0) & m));
    end
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk_in);
    errors++;
    $display("Error watchdog expected finish seen hang");
    wrap_up();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hF39F1735));
    reset_dut();
    legacy_run(2'h0, 2'h0, 2'h0, 2, 1'b0);
    $display("Test reset default done");
    for (int md = 0; md < 4; md++) begin
      for (int wi = 0; wi < 3; wi++) begin
        for (int e = 0; e < 2; e++) begin
          legacy_run(2'(md), 2'(e), (wi == 0) ? 2'h0 : 2'(wi + 1), int'($urandom_range(3, 0)), 1'b1);
        end
      end
    end
    $display("Test legacy widths done");
    for (int s = 0; s < 4; s++) begin
      for (int wi = 0; wi < 3; wi++) begin
        for (int d = 0; d < 2; d++) begin
          sync_run(2'(s), (wi == 0) ? 2'h0 : 2'(wi + 1), d[0]);
        end
      end
    end
    $display("Test sync modes done");
    reset_dut();
    legacy_run(2'h0, 2'h0, 2'h0, 1, 1'b0);
    $display("Test mid-run reset done");
    wrap_up();
  end
endmodule // adc_multilane_read_port_tb_top

`default_nettype wire
